/* File: hdl/ofdr_pkg.sv */
// Package with constants, types and register map for the output fault supervisor
package ofdr_pkg;
	localparam int CLK_MHZ = 10;
	// Latencies in their own units and derived cycle counts (only the ns latency can round down)
	localparam int UV_LAT_NS = 1000;
	localparam int UV_LAT_CYC = (UV_LAT_NS * CLK_MHZ) / 1000;
	localparam int TON_LAT_US = 500;
	localparam int TON_LAT_CYC = TON_LAT_US * CLK_MHZ;
	localparam int OC_LAT_US = 175;
	localparam int OC_LAT_CYC = OC_LAT_US * CLK_MHZ;
	localparam int HICCUP_MS = 25;
	localparam int HICCUP_CYC = HICCUP_MS * 1000 * CLK_MHZ;
	// Turn-on limit step is 0.25 ms, code 0..127 gives 0..31.75 ms
	localparam int TON_STEP_US = 250;
	localparam int TON_STEP_CYC = TON_STEP_US * CLK_MHZ;
	// UV offset step 32 mV, code 1..14 gives 32..448 mV
	localparam logic [3:0] UV_OFS_MIN = 4'h1;
	localparam logic [3:0] UV_OFS_MAX = 4'he;
	localparam logic [7:0] PHASE_ALL = 8'hff;
	localparam logic [6:0] OCL_MIN = 7'h11;
	localparam logic [7:0] OCL_MAX = 8'h82;
	// Register map (word indices on the plain port)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_MASK = 8'h02;
	localparam logic [7:0] REG_CLEAR = 8'h03;
	localparam logic [7:0] REG_UV_OFS = 8'h04;
	localparam logic [7:0] REG_TON_MAX = 8'h05;
	localparam logic [7:0] REG_VOUT_MAX = 8'h06;
	localparam logic [7:0] REG_VOUT_MIN = 8'h07;
	localparam logic [7:0] REG_VOUT_CMD = 8'h08;
	localparam logic [7:0] REG_PHASE = 8'h09;
	localparam logic [7:0] REG_OC_LIMIT = 8'h0a;
	localparam logic [7:0] REG_RESP = 8'h0b;
	localparam logic [7:0] REG_DAC = 8'h0c;
	localparam logic [7:0] REG_FAULT_PIN = 8'h0d;
	// Status bit positions
	localparam int ST_UV = 0;
	localparam int ST_TON = 1;
	localparam int ST_VLIM = 2;
	localparam int ST_OC = 3;
	localparam int ST_OCL = 4;
	localparam int ST_BITS = 5;
	// Fault responses
	typedef enum logic [1:0] {RESP_IGNORE = 2'h0, RESP_LATCH = 2'h1, RESP_HICCUP = 2'h2} ofdr_resp_e;
	// Channel state, Gray along off->start->run->wait
	typedef enum logic [1:0] {CH_OFF = 2'h0, CH_START = 2'h1, CH_RUN = 2'h3, CH_WAIT = 2'h2} ofdr_state_e;
	typedef struct packed {
		logic [3:0] uvOfs;
		logic [6:0] tonMax;
		logic [11:0] voutMax;
		logic [11:0] voutMin;
		logic [11:0] voutCmd;
		logic [9:0] ocLimit;
		logic [1:0] respUv;
		logic [1:0] respTon;
		logic [1:0] respOc;
		logic ocPinEn;
	} ofdr_cfg_s;
	typedef struct packed {
		logic [11:0] senseMv;
		logic [11:0] targetMv;
		logic [11:0] droopMv;
		logic [9:0] totalAmps;
		logic reachedThr;
	} ofdr_meas_s;
	function automatic logic respShuts(input logic [1:0] r);
		respShuts = (r != RESP_IGNORE);
	endfunction : respShuts
endpackage : ofdr_pkg

/* File: hdl/ofdr_filter.sv */
// Persistence filter: output true after condition holds for LAT cycles
module ofdr_filter #(
	parameter int LAT = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cond,
	output logic hit
);
	localparam int W = $clog2(LAT + 1);
	logic [W-1:0] cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (!cond) begin
			cnt_q <= '0;
		end else if (cnt_q != W'(LAT)) begin
			cnt_q <= cnt_q + W'(1);
		end
	end
	assign hit = cond && (cnt_q >= W'(LAT - 1));
endmodule : ofdr_filter

/* File: hdl/ofdr_phase_limit.sv */
// Per-phase cycle-by-cycle current limiter with skip flags
module ofdr_phase_limit #(
	parameter int PHASES = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic running,
	input wire logic [PHASES-1:0] pwmIn,
	input wire logic [PHASES*8-1:0] phaseAmps,
	input wire logic [PHASES*8-1:0] phaseLimit,
	output logic [PHASES-1:0] pwmOut,
	output logic overAny
);
	logic [PHASES-1:0] over;
	logic [PHASES-1:0] pwm_q;
	genvar g;
	generate
		for (g = 0; g < PHASES; g++) begin : gPh
			assign over[g] = running && (phaseAmps[g*8 +: 8] > phaseLimit[g*8 +: 8]);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pwm_q[g] <= 1'b0;
				end else begin
					pwm_q[g] <= pwmIn[g] && !over[g]; // Pulse skipped while over limit
				end
			end
		end
	endgenerate
	assign pwmOut = pwm_q;
	assign overAny = |over;
endmodule : ofdr_phase_limit

/* File: hdl/ofdr_channel.sv */
// One channel of output fault supervision with a plain register port
// Functional notes
// - Tracking UV fault within 1 us when sense below target+droop-offset while running.
// - Turn-on time fault if threshold not reached within limit during soft-start.
// - Commanded level outside min/max is clamped at DAC, warning only.
// - Total over-current fault within 175 us; fault pin assertion configurable.
// - Power-good drops whenever a fault response stops conversion.
// - Every fault sets status and alert unless masked.
// - Faults cleared by enable cycling or clear-faults command.
// - Condition still present at clear sets the fault again at once.
// - Phase select FFh sets channel OC threshold, else per-phase limit.
// - Ignore response acts as warning: status and alert, conversion continues.
// - Latch-off stops at once until enable cycled; restart with turn-on delay.
// - Hiccup stops, waits 25 ms, retries with turn-on delay, repeats.
// - Each channel instance has independent fault logic and shutdown.
module ofdr_channel #(
	parameter int PHASES = 6,
	parameter int HICCUP_CYC = ofdr_pkg::HICCUP_CYC,
	parameter int TON_LAT_CYC = ofdr_pkg::TON_LAT_CYC,
	parameter int OC_LAT_CYC = ofdr_pkg::OC_LAT_CYC,
	parameter int TON_STEP_CYC = ofdr_pkg::TON_STEP_CYC,
	parameter int TON_DELAY_CYC = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chanEnable,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire ofdr_pkg::ofdr_meas_s meas,
	input wire logic [PHASES*8-1:0] phaseAmps,
	input wire logic [PHASES-1:0] pwmIn,
	output logic [PHASES-1:0] pwmOut,
	output logic [PHASES-1:0] pwmOe,
	output logic [11:0] target_voltage_code,
	output logic power_good_out,
	output logic fault_out_n,
	output logic smbAlert_n
);
	localparam int HW = $clog2(HICCUP_CYC + 1);
	localparam int TW = $clog2(127 * TON_STEP_CYC + TON_LAT_CYC + 2);
	ofdr_pkg::ofdr_cfg_s cfg_q;
	ofdr_pkg::ofdr_state_e state_q;
	logic [ofdr_pkg::ST_BITS-1:0] status_q, mask_q;
	logic [7:0] phaseSel_q;
	logic [PHASES*8-1:0] phaseLimit_q;
	logic [31:0] rdata_q;
	logic [HW-1:0] wait_q;
	logic [TW-1:0] ton_q;
	logic enPrev_q, tonFault_q, shutFault_q, pinFault_q;
	logic running, uvCond, uvHit, ocCond, ocHit, overAny, vlimCond, tonHit, clearReq;
	logic [12:0] uvThr;
	logic [ofdr_pkg::ST_BITS-1:0] events;
	logic [11:0] dac;
	logic [PHASES-1:0] pwmLim;
	logic [31:0] rd;
	logic startDone, tripUv, tripTon, tripOc, trip;

	assign running = (state_q == ofdr_pkg::CH_RUN);
	assign clearReq = regWr && (regAddr == ofdr_pkg::REG_CLEAR);

	// Offset in 32 mV steps below target plus droop
	assign uvThr = 13'(meas.targetMv) + 13'(meas.droopMv) - 13'({cfg_q.uvOfs, 5'h00});
	assign uvCond = running && ({1'b0, meas.senseMv} < uvThr);
	ofdr_filter #(.LAT(ofdr_pkg::UV_LAT_CYC)) uUvFilt (
		.clk(clk),
		.rst_n(rst_n),
		.cond(uvCond),
		.hit(uvHit)
	);
	assign ocCond = running && (meas.totalAmps > cfg_q.ocLimit);
	ofdr_filter #(.LAT(OC_LAT_CYC)) uOcFilt (
		.clk(clk),
		.rst_n(rst_n),
		.cond(ocCond),
		.hit(ocHit)
	);
	ofdr_phase_limit #(.PHASES(PHASES)) uPhase (
		.clk(clk),
		.rst_n(rst_n),
		.running(running),
		.pwmIn(pwmIn),
		.phaseAmps(phaseAmps),
		.phaseLimit(phaseLimit_q),
		.pwmOut(pwmLim),
		.overAny(overAny)
	);

	// Clamp to limits, conversion not touched
	always_comb begin
		vlimCond = 1'b0;
		dac = cfg_q.voutCmd;
		if (cfg_q.voutCmd > cfg_q.voutMax) begin
			dac = cfg_q.voutMax;
			vlimCond = running;
		end else if (cfg_q.voutCmd < cfg_q.voutMin) begin
			dac = cfg_q.voutMin;
			vlimCond = running;
		end
	end

	// Soft-start timer: limit plus detection latency
	assign tonHit = (state_q == ofdr_pkg::CH_START) && (ton_q >= TW'(TON_DELAY_CYC))
		&& !meas.reachedThr
		&& (ton_q >= TW'(TON_DELAY_CYC + TON_LAT_CYC) + TW'(cfg_q.tonMax) * TW'(TON_STEP_CYC));
	assign startDone = (state_q == ofdr_pkg::CH_START) && (ton_q >= TW'(TON_DELAY_CYC)) && meas.reachedThr;

	assign tripUv = uvHit && ofdr_pkg::respShuts(cfg_q.respUv);
	assign tripTon = tonHit && ofdr_pkg::respShuts(cfg_q.respTon);
	assign tripOc = ocHit && ofdr_pkg::respShuts(cfg_q.respOc);
	assign trip = tripUv || tripTon || tripOc; // Ignore response never trips

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ofdr_pkg::CH_OFF;
			ton_q <= '0;
			wait_q <= '0;
			enPrev_q <= 1'b0;
			tonFault_q <= 1'b0;
			shutFault_q <= 1'b0;
		end else begin
			enPrev_q <= chanEnable;
			if (!chanEnable) begin
				state_q <= ofdr_pkg::CH_OFF; // Enable low releases latch-off
				shutFault_q <= 1'b0;
			end else begin
				case (state_q)
					ofdr_pkg::CH_OFF: begin
						if (!enPrev_q && !shutFault_q) begin
							state_q <= ofdr_pkg::CH_START;
							ton_q <= '0;
						end
					end
					ofdr_pkg::CH_START: begin
						ton_q <= ton_q + TW'(1);
						if (trip) begin
							shutFault_q <= 1'b1;
							wait_q <= '0;
							state_q <= (tripTon ? cfg_q.respTon : (tripUv ? cfg_q.respUv : cfg_q.respOc))
								== ofdr_pkg::RESP_HICCUP ? ofdr_pkg::CH_WAIT : ofdr_pkg::CH_OFF;
						end else if (startDone) begin
							state_q <= ofdr_pkg::CH_RUN;
						end
					end
					ofdr_pkg::CH_RUN: begin
						if (trip) begin
							shutFault_q <= 1'b1;
							wait_q <= '0;
							state_q <= ((tripUv ? cfg_q.respUv : cfg_q.respOc) == ofdr_pkg::RESP_HICCUP)
								? ofdr_pkg::CH_WAIT : ofdr_pkg::CH_OFF;
						end
					end
					ofdr_pkg::CH_WAIT: begin
						wait_q <= wait_q + HW'(1);
						if (wait_q >= HW'(HICCUP_CYC - 1)) begin
							state_q <= ofdr_pkg::CH_START; // Retry repeats while fault persists
							ton_q <= '0;
						end
					end
					default: state_q <= ofdr_pkg::CH_OFF;
				endcase
			end
			tonFault_q <= tonHit;
		end
	end

	assign events = {overAny, ocHit, vlimCond, tonFault_q, uvHit};

	// Set wins over clear, so a live condition re-flags at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= '0;
		end else if (clearReq || (chanEnable && !enPrev_q)) begin
			status_q <= events;
		end else begin
			status_q <= status_q | events;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinFault_q <= 1'b0;
		end else if (clearReq || !chanEnable) begin
			pinFault_q <= trip && (!tripOc || cfg_q.ocPinEn || tripUv || tripTon);
		end else if (trip && (!tripOc || cfg_q.ocPinEn || tripUv || tripTon)) begin
			pinFault_q <= 1'b1; // OC pin assertion is optional
		end
	end

	// Configuration writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '0;
			cfg_q.uvOfs <= ofdr_pkg::UV_OFS_MIN;
			cfg_q.voutMax <= 12'hfff;
			cfg_q.ocLimit <= 10'h3ff;
			cfg_q.respUv <= ofdr_pkg::RESP_LATCH;
			cfg_q.respTon <= ofdr_pkg::RESP_LATCH;
			cfg_q.respOc <= ofdr_pkg::RESP_LATCH;
			mask_q <= '0;
			phaseSel_q <= ofdr_pkg::PHASE_ALL;
			phaseLimit_q <= {PHASES{ofdr_pkg::OCL_MAX}};
		end else if (regWr) begin
			if (regAddr == ofdr_pkg::REG_MASK) begin
				mask_q <= regWdata[ofdr_pkg::ST_BITS-1:0];
			end else if (regAddr == ofdr_pkg::REG_UV_OFS) begin
				if (regWdata[3:0] >= ofdr_pkg::UV_OFS_MIN && regWdata[3:0] <= ofdr_pkg::UV_OFS_MAX) begin
					cfg_q.uvOfs <= regWdata[3:0];
				end
			end else if (regAddr == ofdr_pkg::REG_TON_MAX) begin
				cfg_q.tonMax <= regWdata[6:0];
			end else if (regAddr == ofdr_pkg::REG_VOUT_MAX) begin
				cfg_q.voutMax <= regWdata[11:0];
			end else if (regAddr == ofdr_pkg::REG_VOUT_MIN) begin
				cfg_q.voutMin <= regWdata[11:0];
			end else if (regAddr == ofdr_pkg::REG_VOUT_CMD) begin
				cfg_q.voutCmd <= regWdata[11:0];
			end else if (regAddr == ofdr_pkg::REG_PHASE) begin
				phaseSel_q <= regWdata[7:0];
			end else if (regAddr == ofdr_pkg::REG_OC_LIMIT) begin
				if (phaseSel_q == ofdr_pkg::PHASE_ALL) begin
					cfg_q.ocLimit <= regWdata[9:0];
				end else if (phaseSel_q < 8'(PHASES) && regWdata[7:0] >= {1'b0, ofdr_pkg::OCL_MIN}
					&& regWdata[7:0] <= ofdr_pkg::OCL_MAX) begin
					phaseLimit_q[phaseSel_q[2:0]*8 +: 8] <= regWdata[7:0];
				end
			end else if (regAddr == ofdr_pkg::REG_RESP) begin
				cfg_q.respUv <= regWdata[1:0];
				cfg_q.respTon <= regWdata[3:2];
				cfg_q.respOc <= regWdata[5:4];
				cfg_q.ocPinEn <= regWdata[6];
			end
		end
	end

	always_comb begin
		rd = 32'h0000_0000;
		if (regAddr == ofdr_pkg::REG_CTRL) begin
			rd = {28'h0, shutFault_q, state_q, chanEnable};
		end else if (regAddr == ofdr_pkg::REG_STATUS) begin
			rd = 32'(status_q);
		end else if (regAddr == ofdr_pkg::REG_MASK) begin
			rd = 32'(mask_q);
		end else if (regAddr == ofdr_pkg::REG_UV_OFS) begin
			rd = 32'(cfg_q.uvOfs);
		end else if (regAddr == ofdr_pkg::REG_TON_MAX) begin
			rd = 32'(cfg_q.tonMax);
		end else if (regAddr == ofdr_pkg::REG_VOUT_MAX) begin
			rd = 32'(cfg_q.voutMax);
		end else if (regAddr == ofdr_pkg::REG_VOUT_MIN) begin
			rd = 32'(cfg_q.voutMin);
		end else if (regAddr == ofdr_pkg::REG_VOUT_CMD) begin
			rd = 32'(cfg_q.voutCmd);
		end else if (regAddr == ofdr_pkg::REG_PHASE) begin
			rd = 32'(phaseSel_q);
		end else if (regAddr == ofdr_pkg::REG_OC_LIMIT) begin
			rd = (phaseSel_q == ofdr_pkg::PHASE_ALL) ? 32'(cfg_q.ocLimit)
				: (phaseSel_q < 8'(PHASES) ? 32'(phaseLimit_q[phaseSel_q[2:0]*8 +: 8]) : 32'h0000_0000);
		end else if (regAddr == ofdr_pkg::REG_RESP) begin
			rd = {25'h0, cfg_q.ocPinEn, cfg_q.respOc, cfg_q.respTon, cfg_q.respUv};
		end else if (regAddr == ofdr_pkg::REG_DAC) begin
			rd = 32'(dac);
		end else if (regAddr == ofdr_pkg::REG_FAULT_PIN) begin
			rd = 32'(pinFault_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (regRd) begin
			rdata_q <= rd;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			target_voltage_code <= 12'h000;
			power_good_out <= 1'b0;
			fault_out_n <= 1'b1;
			smbAlert_n <= 1'b1;
		end else begin
			target_voltage_code <= dac;
			// Disable also drops it, so it never outlives the released drivers
			power_good_out <= running && !trip && chanEnable;
			fault_out_n <= !pinFault_q;
			smbAlert_n <= !(|(status_q & ~mask_q));
		end
	end

	// Drivers released outside start and run, so a fault shutdown leaves them floating
	assign pwmOut = pwmLim;
	assign pwmOe = (running || state_q == ofdr_pkg::CH_START) ? {PHASES{1'b1}} : {PHASES{1'b0}};
	assign regRdata = rdata_q;
endmodule : ofdr_channel

/* File: sim/ofdr_channel_monitor.sv */
// Port checker for one supervised channel
module ofdr_channel_monitor #(
	parameter int PHASES = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chanEnable,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic [PHASES-1:0] pwmIn,
	input wire logic [PHASES-1:0] pwmOut,
	input wire logic [PHASES-1:0] pwmOe,
	input wire logic [11:0] target_voltage_code,
	input wire logic power_good_out,
	input wire logic fault_out_n,
	input wire logic smbAlert_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		!$past(regRd) |-> regRdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside its answer cycle");
	property p_pg_oe;
		power_good_out |-> pwmOe == {PHASES{1'b1}};
	endproperty
	a_pg_oe: assert property (p_pg_oe) else $error("power good while outputs released");
	property p_oe_whole;
		pwmOe == '0 || pwmOe == {PHASES{1'b1}};
	endproperty
	a_oe_whole: assert property (p_oe_whole) else $error("phases released apart");
	property p_pwm_gate;
		(pwmOut & ~$past(pwmIn)) == '0;
	endproperty
	a_pwm_gate: assert property (p_pwm_gate) else $error("pulse not from input");
	property p_trip_pg;
		$fell(fault_out_n) |-> ##[0:1] !power_good_out;
	endproperty
	a_trip_pg: assert property (p_trip_pg) else $error("power good kept after trip");
	property p_disable_off;
		$fell(chanEnable) |-> ##[1:3] pwmOe == '0;
	endproperty
	a_disable_off: assert property (p_disable_off) else $error("outputs kept after disable");
	property p_start_delay;
		$rose(chanEnable) |-> !power_good_out [*8];
	endproperty
	a_start_delay: assert property (p_start_delay) else $error("power good before turn-on delay");
	property p_mask_all;
		regWr && regAddr == ofdr_pkg::REG_MASK && regWdata[4:0] == 5'h1f |-> ##[1:2] smbAlert_n;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("alert while all masked");
	property p_dac_stable;
		!regWr [*3] |=> $stable(target_voltage_code);
	endproperty
	a_dac_stable: assert property (p_dac_stable) else $error("DAC code moved without write");
endmodule : ofdr_channel_monitor

bind ofdr_channel ofdr_channel_monitor #(.PHASES(PHASES)) u_mon (.clk(clk), .rst_n(rst_n),
	.chanEnable(chanEnable), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .pwmIn(pwmIn), .pwmOut(pwmOut), .pwmOe(pwmOe),
	.target_voltage_code(target_voltage_code), .power_good_out(power_good_out),
	.fault_out_n(fault_out_n), .smbAlert_n(smbAlert_n));

/* File: sim/ofdr_stage_model.sv */
// Power stage and output rail model feeding channel measurements
module ofdr_stage_model (
	input wire logic clk,
	input wire logic oe,
	input wire logic canReach,
	input wire logic [11:0] dropMv,
	input wire logic [9:0] amps,
	output ofdr_pkg::ofdr_meas_s meas
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] rampQ;
	// Rail ramps only while driven; a stuck ramp never reaches threshold
	always_ff @(posedge clk) begin
		rampQ <= !oe ? 3'h0 : (rampQ == 3'h7 ? rampQ : rampQ + 3'h1);
	end
	// Released rail discharges, so sense reads zero
	assign meas.senseMv = oe ? 12'h384 + meas.droopMv - dropMv : 12'h000;
	assign meas.targetMv = 12'h384;
	// Load line of 1 mV per amp; the rail follows it, so only dropMv reads as under-voltage
	assign meas.droopMv = {2'h0, amps};
	assign meas.totalAmps = amps;
	assign meas.reachedThr = canReach && rampQ[2];
endmodule : ofdr_stage_model

/* File: sim/tb_ofdr_channel.sv */
// Self-checking bench for one supervised channel
module tb_ofdr_channel;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} ofdr_row_s;
	logic clk = 0, rst_n = 0, chanEnable = 0, regWr = 0, regRd = 0, reach = 0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, rdv;
	logic [47:0] phaseAmps = 48'h0;
	logic [5:0] pwmIn = 6'h3f, pwmOut, pwmOe;
	logic [11:0] dropMv = 12'h000, dac;
	logic [9:0] amps = 10'h000;
	logic pg, faultN, alertN;
	ofdr_pkg::ofdr_meas_s meas;
	int num_errors = 0, total_checks = 0, cycles = 0, waitN;
	ofdr_row_s rows [8] = '{'{8'h20, 32'h55, ofdr_pkg::REG_MASK, 32'h0},
		'{ofdr_pkg::REG_VOUT_MAX, 32'h800, ofdr_pkg::REG_DAC, 32'h0},
		'{ofdr_pkg::REG_VOUT_MIN, 32'h100, ofdr_pkg::REG_DAC, 32'h100},
		'{ofdr_pkg::REG_VOUT_CMD, 32'h900, ofdr_pkg::REG_DAC, 32'h800},
		'{ofdr_pkg::REG_VOUT_CMD, 32'h400, ofdr_pkg::REG_DAC, 32'h400},
		'{ofdr_pkg::REG_MASK, 32'h1f, ofdr_pkg::REG_MASK, 32'h1f},
		'{ofdr_pkg::REG_MASK, 32'h0, 8'h20, 32'h0},
		'{ofdr_pkg::REG_CTRL, 32'hf, ofdr_pkg::REG_CTRL, 32'h0}};
	// Shortened counts keep hiccup and latency waits brief
	ofdr_channel #(.PHASES(6), .HICCUP_CYC(50), .TON_LAT_CYC(8), .OC_LAT_CYC(8), .TON_STEP_CYC(4),
		.TON_DELAY_CYC(16)) uut (.clk(clk), .rst_n(rst_n), .chanEnable(chanEnable), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .meas(meas),
		.phaseAmps(phaseAmps), .pwmIn(pwmIn), .pwmOut(pwmOut), .pwmOe(pwmOe), .target_voltage_code(dac),
		.power_good_out(pg), .fault_out_n(faultN), .smbAlert_n(alertN));
	ofdr_stage_model stage (.clk(clk), .oe(pwmOe[0]), .canReach(reach), .dropMv(dropMv), .amps(amps),
		.meas(meas));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_bit(input logic g, input logic e);
		chk_word({31'h0, g}, {31'h0, e});
	endtask : chk_bit
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rdv = regRdata;
	endtask : rd
	task automatic wait_pg(input logic lvl, input int lim);
		waitN = 0;
		while (pg !== lvl && waitN < lim) begin
			@(posedge clk);
			#1 waitN++;
		end
	endtask : wait_pg
	task automatic cycle_enable();
		@(posedge clk);
		chanEnable <= 1'b0;
		repeat (3) @(posedge clk);
		chanEnable <= 1'b1;
	endtask : cycle_enable
	initial begin
		repeat (12) @(posedge clk);
		chk_word({faultN, alertN, pg, pwmOe}, {3'h6, 6'h00});
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			repeat (2) @(posedge clk);
			rd(rows[i].ra);
			chk_word(rdv, rows[i].ex);
		end
		wr(ofdr_pkg::REG_UV_OFS, 32'h2);
		wr(ofdr_pkg::REG_UV_OFS, 32'hf);
		wr(ofdr_pkg::REG_RESP, 32'h0);
		@(posedge clk);
		chanEnable <= 1'b1;
		reach <= 1'b1;
		wait_pg(1'b1, 100);
		chk_bit(waitN > 16, 1'b1);
		// Drop of 48 mV sits inside a 64 mV offset
		dropMv <= 12'h030;
		repeat (20) @(posedge clk);
		rd(ofdr_pkg::REG_STATUS);
		chk_word(rdv, 32'h0);
		dropMv <= 12'h050;
		repeat (20) @(posedge clk);
		chk_bit(pg, 1'b1);
		chk_bit(alertN, 1'b0);
		wr(ofdr_pkg::REG_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk_bit(alertN, 1'b1);
		wr(ofdr_pkg::REG_MASK, 32'h0);
		wr(ofdr_pkg::REG_CLEAR, 32'h1);
		rd(ofdr_pkg::REG_STATUS);
		chk_bit(rdv[ofdr_pkg::ST_UV], 1'b1);
		wr(ofdr_pkg::REG_VOUT_CMD, 32'h900);
		repeat (3) @(posedge clk);
		rd(ofdr_pkg::REG_STATUS);
		chk_bit(rdv[ofdr_pkg::ST_VLIM], 1'b1);
		chk_bit(pg, 1'b1);
		wr(ofdr_pkg::REG_VOUT_CMD, 32'h400);
		dropMv <= 12'h000;
		repeat (3) @(posedge clk);
		wr(ofdr_pkg::REG_CLEAR, 32'h1);
		repeat (2) @(posedge clk);
		rd(ofdr_pkg::REG_STATUS);
		chk_word(rdv, 32'h0);
		chk_bit(alertN, 1'b1);
		wr(ofdr_pkg::REG_RESP, 32'h1);
		dropMv <= 12'h050;
		wait_pg(1'b0, 20);
		chk_bit(waitN <= 14, 1'b1);
		// Fault pin lags power good by one register stage
		repeat (2) @(posedge clk);
		chk_word({faultN, pwmOe}, 32'h0);
		dropMv <= 12'h000;
		repeat (60) @(posedge clk);
		chk_bit(pg, 1'b0);
		cycle_enable();
		wait_pg(1'b1, 100);
		chk_bit(waitN > 16, 1'b1);
		rd(ofdr_pkg::REG_STATUS);
		chk_word(rdv, 32'h0);
		// Hiccup on over-current with the fault pin enabled
		wr(ofdr_pkg::REG_RESP, 32'h65);
		wr(ofdr_pkg::REG_OC_LIMIT, 32'h64);
		amps <= 10'h0c8;
		wait_pg(1'b0, 30);
		repeat (2) @(posedge clk);
		chk_word({pg, faultN}, 32'h0);
		rd(ofdr_pkg::REG_STATUS);
		chk_bit(rdv[ofdr_pkg::ST_OC], 1'b1);
		amps <= 10'h000;
		repeat (40) @(posedge clk);
		chk_bit(pg, 1'b0);
		wait_pg(1'b1, 120);
		chk_bit(pg, 1'b1);
		wr(ofdr_pkg::REG_PHASE, 32'h0);
		wr(ofdr_pkg::REG_OC_LIMIT, 32'h20);
		phaseAmps[7:0] <= 8'h30;
		pwmIn <= 6'h2d;
		repeat (4) @(posedge clk);
		chk_word({pg, pwmOut}, {25'h0, 7'h6c});
		rd(ofdr_pkg::REG_STATUS);
		chk_bit(rdv[ofdr_pkg::ST_OCL], 1'b1);
		phaseAmps <= 48'h0;
		// Rail never reaches threshold with a zero turn-on limit
		wr(ofdr_pkg::REG_RESP, 32'h4);
		wr(ofdr_pkg::REG_TON_MAX, 32'h0);
		reach <= 1'b0;
		cycle_enable();
		repeat (60) @(posedge clk);
		chk_word({pg, faultN, pwmOe}, 32'h0);
		rd(ofdr_pkg::REG_STATUS);
		chk_bit(rdv[ofdr_pkg::ST_TON], 1'b1);
		finish_test();
	end
endmodule : tb_ofdr_channel
